// ### src/smbus_cfg_pkg.sv
// Purpose: Constants for the serial configuration byte bank
// Assumes: Byte-mode access only, four configuration bytes
// Notes:   Shared by design and bench
package smbus_cfg_pkg;
  localparam logic [6:0] SLAVE_ADDR    = 7'h69;
  localparam int         CFG_BYTES     = 4;
  localparam int         GATED_OUTS    = 21;
  localparam logic [1:0] IDX_SPREAD    = 2'h0;
  localparam logic [1:0] IDX_CPU_FIXED = 2'h1;
  localparam logic [1:0] IDX_BUS       = 2'h2;
  localparam logic [1:0] IDX_FREE_REF  = 2'h3;
  localparam int         CMD_BYTE_MODE = 7;
  localparam int         SPREAD_LSB    = 5;
  localparam int         FREQ_WIDTH    = 5;
  localparam logic [7:0] RESET_SPREAD  = 8'h00;
  localparam logic [7:0] RESET_CPU_FIX = 8'hff;
  localparam logic [7:0] RESET_BUS     = 8'h7f;
  localparam logic [7:0] RESET_FREE    = 8'heb;
  localparam logic [7:0] WMASK_SPREAD  = 8'hff;
  localparam logic [7:0] WMASK_CPU_FIX = 8'hff;
  localparam logic [7:0] WMASK_BUS     = 8'h7f;
  localparam logic [7:0] WMASK_FREE    = 8'heb;
  localparam logic [7:0] BLOCK_READ    = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK  = 3'b011,
    ST_RX   = 3'b010,
    ST_TX   = 3'b110,
    ST_RACK = 3'b111
  } bus_state_t;
endpackage : smbus_cfg_pkg

// ### src/smbus_clock_config_bytes.sv
// Purpose: Serial-bus slave holding clock configuration bytes 0 to 3
// Assumes: Bus pins and strap pins are asynchronous to clock
// Notes:   Bus pins sampled at 40 MHz; open-drain data pin
`timescale 1ns/1ps
module smbus_clock_config_bytes (
  input  wire logic                                      clock,
  input  wire logic                                      rst,
  input  wire logic                                      scl,
  input  wire logic                                      sda_in,
  output logic                                           sda_out,
  output logic                                           sda_oe_n,
  input  wire logic                                      frequency_source_override,
  input  wire logic [smbus_cfg_pkg::FREQ_WIDTH-1:0]      fs_pins,
  input  wire logic [smbus_cfg_pkg::GATED_OUTS-1:0]      raw_clocks,
  output logic [smbus_cfg_pkg::GATED_OUTS-1:0]           gated_clocks,
  output logic [2:0]                                     spread_mode,
  output logic [smbus_cfg_pkg::FREQ_WIDTH-1:0]           freq_select
);
  // Input synchronisers
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [1:0] ovr_sync;
  logic [smbus_cfg_pkg::FREQ_WIDTH-1:0] fs_meta;
  logic [smbus_cfg_pkg::FREQ_WIDTH-1:0] fs_sync;
  logic scl_prev;
  logic sda_prev;
  always_ff @(posedge clock) begin // Strap sync runs through reset
    fs_meta <= fs_pins;
    fs_sync <= fs_meta;
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      ovr_sync <= 2'h0;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl};
      sda_sync <= {sda_sync[0], sda_in};
      ovr_sync <= {ovr_sync[0], frequency_source_override};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  assign scl_s      = scl_sync[1];
  assign sda_s      = sda_sync[1];
  assign scl_rise   = scl_s & ~scl_prev;
  assign scl_fall   = ~scl_s & scl_prev;
  assign start_cond = scl_s & scl_prev & sda_prev & ~sda_s;
  assign stop_cond  = scl_s & scl_prev & ~sda_prev & sda_s;

  // Protocol state and configuration bytes
  smbus_cfg_pkg::bus_state_t state;
  smbus_cfg_pkg::bus_state_t next_state;
  logic [3:0]       bitcnt;
  logic [3:0]       next_bitcnt;
  logic [7:0]       shreg;
  logic [7:0]       next_shreg;
  logic             is_read;
  logic             next_is_read;
  logic             have_cmd;
  logic             next_have_cmd;
  logic             byte_mode;
  logic             next_byte_mode;
  logic [6:0]       index;
  logic [6:0]       next_index;
  logic [3:0][7:0]  cfg;
  logic [3:0][7:0]  next_cfg;
  logic             next_oe_n;
  logic [7:0]       rd_byte;
  logic [3:0][7:0]  wmask;
  logic             byte_done;

  assign wmask = {smbus_cfg_pkg::WMASK_FREE, smbus_cfg_pkg::WMASK_BUS,
                  smbus_cfg_pkg::WMASK_CPU_FIX, smbus_cfg_pkg::WMASK_SPREAD};
  assign byte_done = scl_fall && (bitcnt == smbus_cfg_pkg::BITS_PER_BYTE);

  always_comb begin
    if (byte_mode && index < 7'(smbus_cfg_pkg::CFG_BYTES))
      rd_byte = cfg[index[1:0]];
    else
      rd_byte = smbus_cfg_pkg::BLOCK_READ;
  end

  always_comb begin
    next_state     = state;
    next_bitcnt    = bitcnt;
    next_shreg     = shreg;
    next_is_read   = is_read;
    next_have_cmd  = have_cmd;
    next_byte_mode = byte_mode;
    next_index     = index;
    next_cfg       = cfg;
    next_oe_n      = sda_oe_n;
    if (stop_cond) begin
      next_state    = smbus_cfg_pkg::ST_IDLE;
      next_have_cmd = 1'b0;
      next_oe_n     = 1'b1;
    end else if (start_cond) begin
      next_state  = smbus_cfg_pkg::ST_ADDR;
      next_bitcnt = 4'h0;
      next_oe_n   = 1'b1;
    end else begin
      case (state)
        smbus_cfg_pkg::ST_ADDR, smbus_cfg_pkg::ST_RX: begin
          if (scl_rise) begin
            next_shreg  = {shreg[6:0], sda_s};
            next_bitcnt = bitcnt + 4'h1;
          end else if (byte_done) begin
            next_state = smbus_cfg_pkg::ST_ACK;
            next_oe_n  = 1'b0;
            if (state == smbus_cfg_pkg::ST_ADDR) begin
              if (shreg[7:1] == smbus_cfg_pkg::SLAVE_ADDR) begin
                next_is_read = shreg[0];
              end else begin
                next_state = smbus_cfg_pkg::ST_IDLE;
                next_oe_n  = 1'b1;
              end
            end else if (!have_cmd) begin
              next_have_cmd  = 1'b1;
              next_byte_mode = shreg[smbus_cfg_pkg::CMD_BYTE_MODE];
              next_index     = shreg[6:0];
            end else if (byte_mode && index < 7'(smbus_cfg_pkg::CFG_BYTES)) begin
              next_cfg[index[1:0]] = (cfg[index[1:0]] & ~wmask[index[1:0]])
                                   | (shreg & wmask[index[1:0]]);
            end
          end
        end
        smbus_cfg_pkg::ST_ACK: begin
          if (scl_fall) begin
            next_bitcnt = 4'h0;
            if (is_read) begin
              next_state = smbus_cfg_pkg::ST_TX;
              next_shreg = rd_byte;
              next_oe_n  = rd_byte[7];
            end else begin
              next_state = smbus_cfg_pkg::ST_RX;
              next_oe_n  = 1'b1;
            end
          end
        end
        smbus_cfg_pkg::ST_TX: begin
          if (scl_rise) begin
            next_bitcnt = bitcnt + 4'h1;
          end else if (byte_done) begin
            next_state = smbus_cfg_pkg::ST_RACK;
            next_oe_n  = 1'b1;
          end else if (scl_fall) begin
            next_shreg = {shreg[6:0], 1'b0};
            next_oe_n  = shreg[6];
          end
        end
        smbus_cfg_pkg::ST_RACK: begin
          if (scl_rise) begin
            next_shreg[0] = sda_s;
          end else if (scl_fall) begin
            next_bitcnt = 4'h0;
            if (shreg[0]) begin
              next_state = smbus_cfg_pkg::ST_IDLE;
            end else begin
              next_state = smbus_cfg_pkg::ST_TX;
              next_shreg = rd_byte;
              next_oe_n  = rd_byte[7];
            end
          end
        end
        default: begin
          next_state = smbus_cfg_pkg::ST_IDLE;
          next_oe_n  = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state     <= smbus_cfg_pkg::ST_IDLE;
      bitcnt    <= 4'h0;
      shreg     <= 8'h00;
      is_read   <= 1'b0;
      have_cmd  <= 1'b0;
      byte_mode <= 1'b0;
      index     <= 7'h00;
      cfg       <= {smbus_cfg_pkg::RESET_FREE, smbus_cfg_pkg::RESET_BUS,
                    smbus_cfg_pkg::RESET_CPU_FIX, smbus_cfg_pkg::RESET_SPREAD};
      sda_oe_n  <= 1'b1;
      sda_out   <= 1'b0;
    end else begin
      state     <= next_state;
      bitcnt    <= next_bitcnt;
      shreg     <= next_shreg;
      is_read   <= next_is_read;
      have_cmd  <= next_have_cmd;
      byte_mode <= next_byte_mode;
      index     <= next_index;
      cfg       <= next_cfg;
      sda_oe_n  <= next_oe_n;
      sda_out   <= 1'b0;
    end
  end
  // Output enables, frequency source and spread selection
  logic [smbus_cfg_pkg::GATED_OUTS-1:0] en_all;
  logic [smbus_cfg_pkg::GATED_OUTS-1:0] en_live;
  logic [smbus_cfg_pkg::GATED_OUTS-1:0] next_en_live;
  logic [smbus_cfg_pkg::FREQ_WIDTH-1:0] fs_latched;
  logic                                 fs_taken;
  logic [smbus_cfg_pkg::FREQ_WIDTH-1:0] next_freq;
  assign en_all = {cfg[3][7:5], cfg[3][3], cfg[3][1:0],
                   cfg[2][6:0], cfg[1]};
  always_comb begin
    next_en_live = (en_live & raw_clocks) | (en_all & ~raw_clocks);
    next_freq    = ovr_sync[1] ? cfg[0][smbus_cfg_pkg::FREQ_WIDTH-1:0]
                               : fs_latched;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      en_live      <= '0;
      gated_clocks <= '0;
      fs_latched   <= '0;
      fs_taken     <= 1'b0;
      freq_select  <= '0;
      spread_mode  <= 3'h0;
    end else begin
      en_live      <= next_en_live;
      gated_clocks <= raw_clocks & next_en_live;
      fs_taken     <= 1'b1;
      if (!fs_taken)
        fs_latched <= fs_sync;
      freq_select  <= next_freq;
      spread_mode  <= cfg[0][7:smbus_cfg_pkg::SPREAD_LSB];
    end
  end

  // Checks
  a_addr_reject: assert property (@(posedge clock) disable iff (rst)
    (state == smbus_cfg_pkg::ST_ADDR && byte_done && !start_cond && !stop_cond
     && shreg[7:1] != smbus_cfg_pkg::SLAVE_ADDR) |=> state == smbus_cfg_pkg::ST_IDLE && sda_oe_n)
    else $error("foreign address acknowledged");
  a_addr_ack: assert property (@(posedge clock) disable iff (rst)
    (state == smbus_cfg_pkg::ST_ADDR && byte_done && !start_cond && !stop_cond
     && shreg[7:1] == smbus_cfg_pkg::SLAVE_ADDR) |=> !sda_oe_n && is_read == $past(shreg[0]))
    else $error("own address not acknowledged");
  a_cmd_capture: assert property (@(posedge clock) disable iff (rst)
    (state == smbus_cfg_pkg::ST_RX && byte_done && !have_cmd && !start_cond && !stop_cond)
    |=> !sda_oe_n && index == $past(shreg[6:0]) && byte_mode == $past(shreg[7]))
    else $error("command byte not captured");
  a_write_store: assert property (@(posedge clock) disable iff (rst)
    (state == smbus_cfg_pkg::ST_RX && byte_done && have_cmd && byte_mode && index == 7'h01
     && !start_cond && !stop_cond) |=> cfg[1] == $past(shreg) && !sda_oe_n)
    else $error("data byte not stored");
  a_block_nowrite: assert property (@(posedge clock) disable iff (rst)
    (have_cmd && !byte_mode) |=> $stable(cfg))
    else $error("block command changed a byte");
  a_read_first: assert property (@(posedge clock) disable iff (rst)
    (state == smbus_cfg_pkg::ST_ACK && is_read && scl_fall && !start_cond && !stop_cond)
    |=> state == smbus_cfg_pkg::ST_TX && sda_oe_n == $past(rd_byte[7]))
    else $error("read data not driven");
  a_reserved_zero: assert property (@(posedge clock) disable iff (rst)
    cfg[2][7] == 1'b0 && cfg[3][4] == 1'b0 && cfg[3][2] == 1'b0)
    else $error("reserved bit set");
  a_reset_bytes: assert property (@(posedge clock)
    ($past(rst) && !rst) |-> cfg == {smbus_cfg_pkg::RESET_FREE, smbus_cfg_pkg::RESET_BUS,
                                     smbus_cfg_pkg::RESET_CPU_FIX, smbus_cfg_pkg::RESET_SPREAD})
    else $error("bytes not at defaults");
  a_freq_source: assert property (@(posedge clock) disable iff (rst)
    fs_taken |=> freq_select == ($past(ovr_sync[1]) ? $past(cfg[0][4:0]) : $past(fs_latched)))
    else $error("frequency source wrong");
  a_spread_out: assert property (@(posedge clock) disable iff (rst)
    ##1 spread_mode == $past(cfg[0][7:5]))
    else $error("spread mode not following byte 0");
  a_clean_gate: assert property (@(posedge clock) disable iff (rst)
    ((en_live ^ $past(en_live)) & $past(raw_clocks)) == '0)
    else $error("enable changed during high phase");
endmodule : smbus_clock_config_bytes

// ### verification/smbus_host_model.sv
// Purpose: Bus host model for byte write and byte read
// Assumes: Bit time of 8 clock cycles (200 ns), pull-up on data
// Notes:   Drives on the falling clock edge
`timescale 1ns/1ps
module smbus_host_model (
  input  wire logic clock,
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda_host
);
  initial begin
    scl = 1'b1;
    sda_host = 1'b1;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : wait_cyc
  // Data set in low phase, answer taken at scl rise
  task automatic bit_slot(input logic b, output logic seen);
    wait_cyc(2);
    sda_host = b;
    wait_cyc(2);
    scl = 1'b1;
    seen = sda_wire;
    wait_cyc(4);
    scl = 1'b0;
  endtask : bit_slot
  task automatic start_cond;
    if (scl == 1'b0) begin
      wait_cyc(2);
      sda_host = 1'b1;
      wait_cyc(2);
      scl = 1'b1;
    end
    wait_cyc(4);
    sda_host = 1'b0;
    wait_cyc(4);
    scl = 1'b0;
  endtask : start_cond
  task automatic stop_cond;
    wait_cyc(2);
    sda_host = 1'b0;
    wait_cyc(2);
    scl = 1'b1;
    wait_cyc(4);
    sda_host = 1'b1;
    wait_cyc(4);
  endtask : stop_cond
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(b[i], s);
    end
    bit_slot(1'b1, s);
    ack = ~s;
  endtask : send_byte
  task automatic write_cfg(input logic [7:0] adr, cmd, d, output logic [2:0] acks);
    start_cond();
    send_byte(adr, acks[2]);
    send_byte(cmd, acks[1]);
    send_byte(d, acks[0]);
    stop_cond();
  endtask : write_cfg
  task automatic read_cfg(input logic [7:0] cmd, output logic [7:0] d,
                          output logic [2:0] acks);
    logic s;
    start_cond();
    send_byte({smbus_cfg_pkg::SLAVE_ADDR, 1'b0}, acks[2]);
    send_byte(cmd, acks[1]);
    start_cond();
    send_byte({smbus_cfg_pkg::SLAVE_ADDR, 1'b1}, acks[0]);
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, s);
      d[i] = s;
    end
    bit_slot(1'b1, s);
    stop_cond();
  endtask : read_cfg
endmodule : smbus_host_model

// ### verification/tb_smbus_clock_config_bytes.sv
// Purpose: Self-checking bench for the configuration byte bank
// Assumes: Host model with 200 ns bit time
// Notes:   Inputs change on the falling clock edge
`timescale 1ns/1ps
module tb_smbus_clock_config_bytes;
  logic        clock;
  logic        rst;
  logic        scl;
  logic        sda_host;
  logic        sda_out;
  logic        sda_oe_n;
  logic        sda_wire;
  logic        frequency_source_override;
  logic [4:0]  fs_pins;
  logic [20:0] raw_clocks;
  logic [20:0] gated_clocks;
  logic [2:0]  spread_mode;
  logic [4:0]  freq_select;
  logic [7:0]  rd;
  logic [2:0]  acks;
  int          failures;
  int          checks_done;

  // Open-drain data line with pull-up
  assign sda_wire = sda_host & (sda_oe_n | sda_out);
  initial clock = 1'b0;
  always #12.5 clock = ~clock;
  always @(negedge clock) raw_clocks <= rst ? 21'h0 : ~raw_clocks;

  smbus_clock_config_bytes smbus_clock_config_bytes_inst (
    .clock(clock), .rst(rst), .scl(scl), .sda_in(sda_wire), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .frequency_source_override(frequency_source_override),
    .fs_pins(fs_pins), .raw_clocks(raw_clocks), .gated_clocks(gated_clocks),
    .spread_mode(spread_mode), .freq_select(freq_select)
  );
  smbus_host_model smbus_host_model_inst (
    .clock(clock), .sda_wire(sda_wire), .scl(scl), .sda_host(sda_host)
  );

  task automatic cmp_byte(input string what, input logic [7:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_byte
  task automatic cmp_gates(input string what, input logic [20:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_gates
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  task automatic do_reset;
    rst = 1'b1;
    repeat (2) @(negedge clock);
    cmp_gates("gates in reset", 21'h0, gated_clocks);
    cmp_byte("release in reset", 8'h01, {7'h0, sda_oe_n});
    rst = 1'b0;
    repeat (4) @(negedge clock);
  endtask : do_reset
  task automatic wr(input logic [7:0] adr, cmd, d, input logic [2:0] exp_acks);
    smbus_host_model_inst.write_cfg(adr, cmd, d, acks);
    cmp_byte("write acks", {5'h0, exp_acks}, {5'h0, acks});
  endtask : wr
  task automatic rdc(input logic [7:0] cmd, exp);
    smbus_host_model_inst.read_cfg(cmd, rd, acks);
    cmp_byte("read acks", 8'h07, {5'h0, acks});
    cmp_byte("read data", exp, rd);
  endtask : rdc
  function automatic logic [20:0] gmask(input logic [7:0] b1, b2, b3);
    return {b3[7:5], b3[3], b3[1:0], b2[6:0], b1};
  endfunction : gmask
  // Gated outputs follow raw clocks under the enable mask
  task automatic chk_gates(input logic [20:0] mask);
    repeat (4) begin
      @(posedge clock);
      #1;
      cmp_gates("gated clocks", raw_clocks & mask, gated_clocks);
    end
  endtask : chk_gates

  initial begin
    #1ms;
    failures++;
    $display("watchdog expired");
    complete_run();
  end

  initial begin
    rst = 1'b1;
    frequency_source_override = 1'b0;
    fs_pins = 5'h0a;
    raw_clocks = 21'h0;
    failures = 0;
    checks_done = 0;
    do_reset();
    cmp_byte("freq from pins", 8'h0a, {3'h0, freq_select});
    cmp_byte("spread reset", 8'h00, {5'h0, spread_mode});
    rdc(8'h80, 8'h00);
    rdc(8'h81, 8'hff);
    rdc(8'h82, 8'h7f);
    rdc(8'h83, 8'heb);
    chk_gates(21'h1fffff);
    $display("test defaults done");
    for (int m = 0; m < 8; m++) begin
      wr(8'hd2, 8'h80, {m[2:0], 5'h15}, 3'h7);
      cmp_byte("spread mode", {5'h0, m[2:0]}, {5'h0, spread_mode});
      cmp_byte("freq pins kept", 8'h0a, {3'h0, freq_select});
    end
    frequency_source_override = 1'b1;
    repeat (6) @(negedge clock);
    cmp_byte("freq software", 8'h15, {3'h0, freq_select});
    rdc(8'h80, 8'hf5);
    $display("test spread done");
    wr(8'hd2, 8'h81, 8'h5a, 3'h7);
    wr(8'hd2, 8'h82, 8'hff, 3'h7);
    wr(8'hd2, 8'h83, 8'h14, 3'h7);
    rdc(8'h81, 8'h5a);
    rdc(8'h82, 8'h7f);
    rdc(8'h83, 8'h00);
    chk_gates(gmask(8'h5a, 8'h7f, 8'h00));
    wr(8'hd2, 8'h82, 8'h2a, 3'h7);
    wr(8'hd2, 8'h83, 8'hea, 3'h7);
    chk_gates(gmask(8'h5a, 8'h2a, 8'hea));
    $display("test enables done");
    wr(8'hd4, 8'h81, 8'h00, 3'h0);
    wr(8'hd2, 8'h01, 8'h00, 3'h7);
    rdc(8'h81, 8'h5a);
    rdc(8'h00, 8'h00);
    wr(8'hd2, 8'h84, 8'h33, 3'h7);
    rdc(8'h84, 8'h00);
    $display("test refusals done");
    do_reset();
    rdc(8'h81, 8'hff);
    rdc(8'h80, 8'h00);
    $display("test second reset done");
    complete_run();
  end
endmodule : tb_smbus_clock_config_bytes
